// ---- hdl/adc_cfg_pkg.sv ----
// constants, field layouts and types of the serial configuration register map
// assumes a single 100 MHz reference clock and a three-wire serial host
package adc_cfg_pkg;
  localparam logic [12:0] ADDR_PORT_CFG = 13'h000;
  localparam logic [12:0] ADDR_PART_ID = 13'h001;
  localparam logic [12:0] ADDR_SPEED_GRADE = 13'h002;
  localparam logic [12:0] ADDR_PROG_FIRST = 13'h008;
  localparam logic [12:0] ADDR_PROG_LAST = 13'h02d;
  localparam logic [12:0] ADDR_COMMIT = 13'h0ff;
  localparam logic [7:0] PORT_CFG_RST = 8'h18;
  localparam logic [7:0] PROG_RST = 8'h00;
  // arbitrary neutral part code
  localparam logic [7:0] PART_ID_DEFAULT = 8'h5a;
  localparam int COMMIT_POS = 0;
  localparam int GRADE_POS = 4;
  localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam int PROG_SLOTS = 38;

  typedef struct packed {
    logic zero_hi;
    logic lsb_first_hi;
    logic soft_reset_hi;
    logic one_hi;
    logic one_lo;
    logic soft_reset_lo;
    logic lsb_first_lo;
    logic zero_lo;
  } port_cfg_t;

  typedef struct packed {
    logic read;
    logic [1:0] length;
    logic [12:0] addr;
  } instr_t;

  typedef struct packed {
    logic sclk;
    logic csb_n;
    logic sdio;
  } pins_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA = 2'b11,
    ST_HOLD = 2'b10
  } spi_state_t;
endpackage

// ---- hdl/adc_spi_regmap.sv ----
// serial-port slave and byte-wide configuration register map
// assumes the host pins are asynchronous to ref_clk and sclk runs well below ref_clk/6
`timescale 1ns/1ps
module adc_spi_regmap
  import adc_cfg_pkg::*;
#(
  parameter logic [7:0] PART_ID = adc_cfg_pkg::PART_ID_DEFAULT,
  parameter logic [1:0] SPEED_GRADE = 2'b00,
  parameter int PROG_COUNT = adc_cfg_pkg::PROG_SLOTS
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  output logic lsb_first,
  output logic soft_reset,
  output adc_cfg_pkg::port_cfg_t port_cfg,
  output logic [PROG_COUNT-1:0][7:0] prog_active
);
  import adc_cfg_pkg::*;

  if (PROG_COUNT < 1 || PROG_COUNT > PROG_SLOTS)
  begin : g_check
    $error("PROG_COUNT out of range");
  end

  pins_t s1_q, s2_q, s3_q, filt_q, filt_d, raw;
  spi_state_t state_q;
  instr_t instr_q;
  port_cfg_t port_cfg_q;
  logic [15:0] rx_q, rx_d;
  logic [3:0] cnt_q;
  logic [1:0] bytes_q;
  logic [12:0] addr_q, addr_next;
  logic [7:0] tx_q, byte_in;
  logic [7:0] master_q [PROG_COUNT];
  logic [PROG_COUNT-1:0][7:0] slave_q;
  logic rise, fall, instr_done, byte_done, wr_byte, commit_q, srst_q, sdio_o_q, oe_q;

  assign raw = '{sclk: sclk, csb_n: csb_n, sdio: sdio_i};

  // three-stage capture; a change counts once stages two and three agree
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '{sclk: 1'b0, csb_n: 1'b1, sdio: 1'b0};
      s2_q <= '{sclk: 1'b0, csb_n: 1'b1, sdio: 1'b0};
      s3_q <= '{sclk: 1'b0, csb_n: 1'b1, sdio: 1'b0};
      filt_q <= '{sclk: 1'b0, csb_n: 1'b1, sdio: 1'b0};
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  assign filt_d = pins_t'((~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q));
  assign rise = filt_d.sclk & ~filt_q.sclk;
  assign fall = ~filt_d.sclk & filt_q.sclk;
  assign lsb_first = port_cfg_q.lsb_first_hi | port_cfg_q.lsb_first_lo;
  assign rx_d = lsb_first ? {filt_d.sdio, rx_q[15:1]} : {rx_q[14:0], filt_d.sdio};
  assign byte_in = lsb_first ? rx_d[15:8] : rx_d[7:0];
  assign instr_done = (state_q == ST_INSTR) && rise && (cnt_q == INSTR_LAST_BIT);
  assign byte_done = (state_q == ST_DATA) && rise && (cnt_q == BYTE_LAST_BIT);
  assign wr_byte = byte_done && !instr_q.read;
  assign addr_next = lsb_first ? addr_q + 13'h001 : addr_q - 13'h001;

  function automatic logic in_prog(input logic [12:0] a);
    in_prog = (a >= ADDR_PROG_FIRST) && (a < ADDR_PROG_FIRST + 13'(PROG_COUNT));
  endfunction

  function automatic logic [7:0] flip(input logic [7:0] b, input logic rev);
    logic [7:0] r;
    r = b;
    if (rev)
    begin
      for (int i = 0; i < 8; i++)
        r[i] = b[7 - i];
    end
    flip = r;
  endfunction

  // unmapped and out-of-scope addresses read zero; commit bit self-clears
  function automatic logic [7:0] read_reg(input logic [12:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_PORT_CFG)
      v = port_cfg_q;
    else if (a == ADDR_PART_ID)
      v = PART_ID;
    else if (a == ADDR_SPEED_GRADE)
      v[GRADE_POS +: 2] = SPEED_GRADE;
    else if (in_prog(a))
      v = master_q[6'(a - ADDR_PROG_FIRST)];
    read_reg = v;
  endfunction

  // frame sequencer; csb high anywhere drops the frame
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      bytes_q <= 2'b00;
      rx_q <= 16'h0000;
      instr_q <= '0;
      addr_q <= 13'h000;
    end
    else if (filt_d.csb_n)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
    end
    else
    begin
      if (rise)
      begin
        rx_q <= rx_d;
      end
      unique case (state_q)
        ST_IDLE:
          state_q <= ST_INSTR;
        ST_INSTR:
          if (rise)
          begin
            cnt_q <= cnt_q + 4'h1;
            if (instr_done)
            begin
              instr_q <= instr_t'(rx_d);
              addr_q <= rx_d[12:0];
              bytes_q <= 2'b00;
              cnt_q <= 4'h0;
              state_q <= ST_DATA;
            end
          end
        ST_DATA:
          if (rise)
          begin
            cnt_q <= cnt_q + 4'h1;
            if (byte_done)
            begin
              cnt_q <= 4'h0;
              addr_q <= addr_next;
              bytes_q <= bytes_q + 2'b01;
              if (instr_q.length != 2'b11 && bytes_q == instr_q.length)
                state_q <= ST_HOLD;
            end
          end
        ST_HOLD:
          state_q <= ST_HOLD;
      endcase
    end
  end

  // read path: byte loaded on the closing rising edge, bits leave on falling edges
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_q <= 8'h00;
      sdio_o_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      if (instr_done)
        tx_q <= flip(read_reg(rx_d[12:0]), lsb_first);
      else if (byte_done)
        tx_q <= flip(read_reg(addr_next), lsb_first);
      else if (fall && state_q == ST_DATA && instr_q.read)
        tx_q <= {tx_q[6:0], 1'b0};
      if (fall && state_q == ST_DATA && instr_q.read && !filt_d.csb_n)
      begin
        sdio_o_q <= tx_q[7];
        oe_q <= 1'b1;
      end
      else if (filt_d.csb_n || state_q != ST_DATA)
        oe_q <= 1'b0;
    end
  end

  assign sdio_o = sdio_o_q;
  assign sdio_oe = oe_q;

  // port config acts at once; soft reset bits are a pulse and read back zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      port_cfg_q <= PORT_CFG_RST;
      srst_q <= 1'b0;
      commit_q <= 1'b0;
    end
    else
    begin
      srst_q <= wr_byte && addr_q == ADDR_PORT_CFG && (byte_in[5] | byte_in[2]);
      commit_q <= wr_byte && addr_q == ADDR_COMMIT && byte_in[COMMIT_POS];
      if (wr_byte && addr_q == ADDR_PORT_CFG)
      begin
        port_cfg_q <= PORT_CFG_RST;
        port_cfg_q.lsb_first_hi <= byte_in[6];
        port_cfg_q.lsb_first_lo <= byte_in[1];
      end
    end
  end

  assign soft_reset = srst_q;
  assign port_cfg = port_cfg_q;

  // master stage takes writes; slave stage changes only on commit or reset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < PROG_COUNT; i++)
      begin
        master_q[i] <= PROG_RST;
        slave_q[i] <= PROG_RST;
      end
    end
    else if (srst_q)
    begin
      for (int i = 0; i < PROG_COUNT; i++)
      begin
        master_q[i] <= PROG_RST;
        slave_q[i] <= PROG_RST;
      end
    end
    else
    begin
      if (wr_byte && in_prog(addr_q))
        master_q[6'(addr_q - ADDR_PROG_FIRST)] <= byte_in;
      if (commit_q)
      begin
        for (int i = 0; i < PROG_COUNT; i++)
          slave_q[i] <= master_q[i];
      end
    end
  end

  assign prog_active = slave_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_cfg_fixed;
    port_cfg_q.zero_hi == 1'b0 && port_cfg_q.one_hi && port_cfg_q.one_lo && !port_cfg_q.zero_lo;
  endproperty
  a_cfg_fixed: assert property (p_cfg_fixed) else $error("port config fixed bits wrong");

  property p_reset_defaults;
    @(posedge ref_clk) disable iff (1'b0)
      rst |=> port_cfg_q == PORT_CFG_RST && slave_q[0] == PROG_RST && !sdio_oe;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset default missing");

  property p_soft_reset;
    wr_byte && addr_q == ADDR_PORT_CFG && byte_in[5] |-> ##2 master_q[0] == PROG_RST
      && slave_q[0] == PROG_RST;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not applied");

  property p_commit_copy;
    commit_q && !srst_q |=> prog_active[0] == $past(master_q[0]);
  endproperty
  a_commit_copy: assert property (p_commit_copy) else $error("commit did not copy");

  property p_slave_hold;
    !commit_q && !srst_q |=> $stable(slave_q);
  endproperty
  a_slave_hold: assert property (p_slave_hold) else $error("slave changed without commit");

  property p_part_id;
    instr_done && rx_d[15] && rx_d[12:0] == ADDR_PART_ID && !lsb_first |=> tx_q == PART_ID;
  endproperty
  a_part_id: assert property (p_part_id) else $error("part code read wrong");

  property p_grade;
    instr_done && rx_d[15] && rx_d[12:0] == ADDR_SPEED_GRADE && !lsb_first
      |=> tx_q == {2'b00, SPEED_GRADE, 4'h0};
  endproperty
  a_grade: assert property (p_grade) else $error("grade read wrong");

  property p_unmapped;
    instr_done && rx_d[15] && rx_d[12:0] == 13'h003 |=> tx_q == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_oe_frame;
    filt_q.csb_n |-> !sdio_oe;
  endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("sdio driven outside frame");

  c_commit: cover property (commit_q);
  c_soft_reset: cover property (srst_q);
  c_read_drive: cover property (sdio_oe ##1 !sdio_oe);
endmodule

// ---- testbench/spi_host_model.sv ----
// serial host model: drives sclk, csb_n and sdio, one instruction plus one data byte per frame
// assumes the bench muxes the wire level from sdio_oe and feeds it back on sdio_in
`timescale 1ns/1ps
module spi_host_model (
  input wire logic ref_clk,
  input wire logic lsb,
  input wire logic sdio_in,
  output logic sclk,
  output logic csb_n,
  output logic sdio
);
  // 8 ref_clk per half keeps clear of the 3-flop pin filter
  localparam int HALF = 8;
  initial
  begin
    sclk = 1'b0;
    csb_n = 1'b1;
    sdio = 1'b0;
  end
  task automatic xfer(input logic [15:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] seq;
    int b;
    seq = {ins, wd};
    if (lsb)
    begin
      // whole word and byte go out low bit first
      for (b = 0; b < 16; b++) seq[23-b] = ins[b];
      for (b = 0; b < 8; b++) seq[7-b] = wd[b];
    end
    rd = 8'h00;
    for (b = 23; b >= 0; b--)
    begin
      @(negedge ref_clk);
      csb_n = 1'b0;
      // released line shows the inverse, never a stale copy
      if (b >= 8 || !ins[15]) sdio = seq[b];
      else sdio = ~sdio;
      repeat (HALF) @(negedge ref_clk);
      sclk = 1'b1;
      if (b < 8) rd = lsb ? {sdio_in, rd[7:1]} : {rd[6:0], sdio_in};
      repeat (HALF) @(negedge ref_clk);
      sclk = 1'b0;
    end
    repeat (HALF) @(negedge ref_clk);
    csb_n = 1'b1;
    repeat (2 * HALF) @(negedge ref_clk);
  endtask
endmodule

// ---- testbench/adc_spi_regmap_tb.sv ----
// self-checking bench for the serial register map
// assumes the host model on the pins and a 100 MHz ref_clk
`timescale 1ns/1ps
`define CHECK(nm, ex, ac) begin cmp_count++; if ((ac) !== (ex)) begin err_total++; \
  $display("unexpected %s expected %h seen %h", nm, ex, ac); end end
module adc_spi_regmap_tb;
  import adc_cfg_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic lsb = 1'b0;
  logic sclk, csb_n, host_sdio, sdio_o, sdio_oe, lsb_first, soft_reset;
  logic sr_seen = 1'b0;
  logic sdio_i;
  port_cfg_t port_cfg;
  logic [PROG_SLOTS-1:0][7:0] prog_active;
  logic [7:0] rd;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #5 ref_clk = ~ref_clk;
  assign sdio_i = sdio_oe ? sdio_o : host_sdio;
  adc_spi_regmap #(.SPEED_GRADE(2'b10)) adc_spi_regmap_inst (
    .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .csb_n(csb_n), .sdio_i(sdio_i),
    .sdio_o(sdio_o), .sdio_oe(sdio_oe), .lsb_first(lsb_first), .soft_reset(soft_reset),
    .port_cfg(port_cfg), .prog_active(prog_active)
  );
  spi_host_model spi_host_model_inst (
    .ref_clk(ref_clk), .lsb(lsb), .sdio_in(sdio_i), .sclk(sclk), .csb_n(csb_n),
    .sdio(host_sdio)
  );
  always @(posedge ref_clk)
  begin
    if (soft_reset === 1'b1) sr_seen <= 1'b1;
  end
  task automatic complete_run();
    if (err_total == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc > 60000)
    begin
      err_total++;
      complete_run();
    end
  end
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    spi_host_model_inst.xfer({3'b000, a}, d, rd);
  endtask
  task automatic rdreg(input logic [12:0] a, input logic [7:0] ex, input string nm);
    spi_host_model_inst.xfer({3'b100, a}, 8'h00, rd);
    `CHECK(nm, ex, rd)
  endtask
  initial
  begin
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    `CHECK("port_cfg", 8'h18, port_cfg)
    `CHECK("prog_active", '0, prog_active)
    `CHECK("lsb_first", 1'b0, lsb_first)
    `CHECK("sdio_oe", 1'b0, sdio_oe)
    rdreg(ADDR_PORT_CFG, 8'h18, "read port");
    rdreg(ADDR_PART_ID, PART_ID_DEFAULT, "read part");
    rdreg(ADDR_SPEED_GRADE, 8'h20, "read grade");
    wr(ADDR_PART_ID, 8'h00);
    rdreg(ADDR_PART_ID, PART_ID_DEFAULT, "part kept");
    wr(ADDR_PROG_FIRST, 8'hab);
    wr(ADDR_PROG_LAST, 8'h5c);
    `CHECK("held", 8'h00, prog_active[0])
    rdreg(ADDR_PROG_FIRST, 8'hab, "master");
    wr(ADDR_COMMIT, 8'h01);
    repeat (3) @(negedge ref_clk);
    `CHECK("first", 8'hab, prog_active[0])
    `CHECK("last", 8'h5c, prog_active[PROG_SLOTS-1])
    wr(13'h02e, 8'h00);
    rdreg(13'h02e, 8'h00, "unmapped");
    rdreg(13'h003, 8'h00, "gap");
    rdreg(ADDR_COMMIT, 8'h00, "commit");
    wr(ADDR_PORT_CFG, 8'h5a);
    `CHECK("port_cfg lsb", 8'h5a, port_cfg)
    `CHECK("lsb_first on", 1'b1, lsb_first)
    lsb = 1'b1;
    rdreg(ADDR_PROG_FIRST, 8'hab, "lsb read");
    wr(ADDR_PORT_CFG, 8'h18);
    lsb = 1'b0;
    `CHECK("lsb_first off", 1'b0, lsb_first)
    wr(ADDR_PORT_CFG, 8'h3c);
    `CHECK("soft pulse", 1'b1, sr_seen)
    `CHECK("soft active", '0, prog_active)
    `CHECK("soft port", 8'h18, port_cfg)
    rdreg(ADDR_PROG_FIRST, 8'h00, "soft master");
    wr(ADDR_PROG_FIRST, 8'h11);
    wr(ADDR_COMMIT, 8'h01);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    `CHECK("rst active", '0, prog_active)
    rdreg(ADDR_PROG_FIRST, 8'h00, "rst master");
    complete_run();
  end
endmodule
